// >>> verilog/atc_timer_ctrl.sv
// Control logic of an advanced timer: run, update, one-shot, direction,
// alignment, reload buffering and sampling divider, via AXI4-Lite.
// Assumes a single clock; trigger and slave update inputs arrive async.
`include "atc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module atc_timer_ctrl #(
    parameter int CNT_W = 16
) (
    input  wire logic              core_clk,       // Timer clock, 10 MHz
    input  wire logic              rst,            // Sync reset, active high
    input  wire logic              trig_mode,      // Trigger slave mode on
    input  wire logic              encoder_mode,   // Encoder mode on
    input  wire logic              encoder_dir,    // Encoder direction, 1=down
    input  wire logic              trig_in,        // Trigger input, async
    input  wire logic              slave_update,   // Slave update level, async
    input  wire logic [11:0]       s_axi_awaddr,   // Write address
    input  wire logic              s_axi_awvalid,  // Write address valid
    output logic                   s_axi_awready,  // Write address ready
    input  wire logic [31:0]       s_axi_wdata,    // Write data
    input  wire logic [3:0]        s_axi_wstrb,    // Write strobes
    input  wire logic              s_axi_wvalid,   // Write data valid
    output logic                   s_axi_wready,   // Write data ready
    output logic [1:0]             s_axi_bresp,    // Write response
    output logic                   s_axi_bvalid,   // Write response valid
    input  wire logic              s_axi_bready,   // Write response ready
    input  wire logic [11:0]       s_axi_araddr,   // Read address
    input  wire logic              s_axi_arvalid,  // Read address valid
    output logic                   s_axi_arready,  // Read address ready
    output logic [31:0]            s_axi_rdata,    // Read data
    output logic [1:0]             s_axi_rresp,    // Read response
    output logic                   s_axi_rvalid,   // Read data valid
    input  wire logic              s_axi_rready,   // Read data ready
    output logic [CNT_W-1:0]       count_value,    // Counter value
    output logic                   counting_down,  // Current direction
    output logic                   update_event,   // Update pulse
    output logic                   sample_tick,    // Dead-time/filter tick
    output logic                   irq             // Level interrupt
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("CNT_W must be within 2..32");
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = val[i*8 +: 8];
        end
        return r;
    endfunction : wmerge

    function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
        logic [31:0] r;
        r = '0;
        r[CNT_W-1:0] = v;
        return r;
    endfunction : widen

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] trig_sync_q, trig_sync_d;
    logic [1:0] supd_sync_q, supd_sync_d;
    logic       trig_prev_q, trig_prev_d;
    logic       supd_prev_q, supd_prev_d;

    always_comb begin
        trig_sync_d = {trig_sync_q[0], trig_in};
        supd_sync_d = {supd_sync_q[0], slave_update};
        trig_prev_d = trig_sync_q[1];
        supd_prev_d = supd_sync_q[1];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_sync_q <= 2'h0;
            supd_sync_q <= 2'h0;
            trig_prev_q <= 1'b0;
            supd_prev_q <= 1'b0;
        end else begin
            trig_sync_q <= trig_sync_d;
            supd_sync_q <= supd_sync_d;
            trig_prev_q <= trig_prev_d;
            supd_prev_q <= supd_prev_d;
        end
    end

    logic trig_rise;
    logic supd_rise;
    assign trig_rise = trig_sync_q[1] & ~trig_prev_q;
    assign supd_rise = supd_sync_q[1] & ~supd_prev_q;

    // ------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------
    atc_pkg::atc_wr_state_t wst_q, wst_d;
    logic [11:0]      awaddr_q, awaddr_d;
    logic             awhave_q, awhave_d;
    logic [31:0]      wdata_q, wdata_d;
    logic [3:0]       wstrb_q, wstrb_d;
    logic             whave_q, whave_d;
    logic [1:0]       bresp_q, bresp_d;
    logic             rvalid_q, rvalid_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [1:0]       rresp_q, rresp_d;
    logic [15:0]      ctrl_q, ctrl_d;
    logic [CNT_W-1:0] reload_wr_q, reload_wr_d;
    logic [CNT_W-1:0] reload_act_q, reload_act_d;
    logic [CNT_W-1:0] psc_wr_q, psc_wr_d;
    logic [CNT_W-1:0] psc_act_q, psc_act_d;
    logic [CNT_W-1:0] cmp_wr_q, cmp_wr_d;
    logic [CNT_W-1:0] cmp_act_q, cmp_act_d;
    logic [2:0]       status_q, status_d;
    logic [2:0]       mask_q, mask_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] pcnt_q, pcnt_d;
    logic             down_q, down_d;
    logic [1:0]       div_q, div_d;
    logic             upd_q, upd_d;

    logic        wr_go, rd_go, sw_upd, ovf, upd_ev, upd_irq, cmp_hit;
    logic [31:0] wv, ctrl_w;
    logic [1:0]  align;
    logic        centre;

    assign align  = ctrl_q[`ATC_F_ALIGN_HI:`ATC_F_ALIGN_LO];
    assign centre = (align != `ATC_ALIGN_EDGE);

    assign s_axi_awready = (wst_q == atc_pkg::ATC_WR_IDLE) & ~awhave_q;
    assign s_axi_wready  = (wst_q == atc_pkg::ATC_WR_IDLE) & ~whave_q;
    assign s_axi_bvalid  = (wst_q == atc_pkg::ATC_WR_RESP);
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    assign wr_go  = (wst_q == atc_pkg::ATC_WR_HOLD);
    assign rd_go  = s_axi_arvalid & ~rvalid_q;
    assign wv     = wdata_q;
    assign sw_upd = wr_go & (awaddr_q == `ATC_OFF_CMD)
                    & wstrb_q[0] & wv[`ATC_B_CMD_UPD];
    assign ctrl_w = wmerge({16'h0000, ctrl_q}, wv, wstrb_q);

    // Counter wraps at reload value; centre modes turn at both ends
    always_comb begin
        ovf = 1'b0;
        if (ctrl_q[`ATC_B_RUN] && psc_q_tick()) begin
            if (down_q) ovf = (cnt_q == '0);
            else        ovf = (cnt_q == reload_act_q);
        end
    end

    function automatic logic psc_q_tick();
        return pcnt_q == psc_act_q;
    endfunction : psc_q_tick

    assign upd_ev  = ~ctrl_q[`ATC_B_UINH] & (ovf | sw_upd | supd_rise);
    assign upd_irq = upd_ev & (ovf | ~ctrl_q[`ATC_B_URS]);
    assign cmp_hit = ctrl_q[`ATC_B_RUN] & psc_q_tick() & (cnt_q == cmp_act_q)
                     & (align == `ATC_ALIGN_EDGE ? 1'b1 :
                        align == `ATC_ALIGN_DOWN ? down_q :
                        align == `ATC_ALIGN_UP   ? ~down_q : 1'b1);

    always_comb begin
        wst_d = wst_q;
        awaddr_d = awaddr_q;
        awhave_d = awhave_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        whave_d = whave_q;
        bresp_d = bresp_q;
        case (wst_q)
            atc_pkg::ATC_WR_IDLE: begin
                if (s_axi_awvalid && !awhave_q) begin
                    awaddr_d = s_axi_awaddr;
                    awhave_d = 1'b1;
                end
                if (s_axi_wvalid && !whave_q) begin
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                    whave_d = 1'b1;
                end
                if (awhave_d && whave_d) wst_d = atc_pkg::ATC_WR_HOLD;
            end
            atc_pkg::ATC_WR_HOLD: begin
                awhave_d = 1'b0;
                whave_d  = 1'b0;
                bresp_d  = (awaddr_q[1:0] == 2'h0 &&
                            awaddr_q <= `ATC_OFF_MASK &&
                            awaddr_q != `ATC_OFF_COUNT &&
                            awaddr_q != `ATC_OFF_STATUS)
                           ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
                wst_d    = atc_pkg::ATC_WR_RESP;
            end
            atc_pkg::ATC_WR_RESP: begin
                if (s_axi_bready) wst_d = atc_pkg::ATC_WR_IDLE;
            end
            default: wst_d = atc_pkg::ATC_WR_IDLE;
        endcase
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = `ATC_RESP_OKAY;
            case (s_axi_araddr)
                `ATC_OFF_CTRL:     rdata_d = {16'h0000,
                                              ctrl_q & `ATC_CTRL_MASK};
                `ATC_OFF_RELOAD:   rdata_d = widen(reload_wr_q);
                `ATC_OFF_PRESCALE: rdata_d = widen(psc_wr_q);
                `ATC_OFF_COMPARE:  rdata_d = widen(cmp_wr_q);
                `ATC_OFF_COUNT:    rdata_d = widen(cnt_q);
                `ATC_OFF_CMD:      rdata_d = 32'h0000_0000;
                `ATC_OFF_STATUS:   rdata_d = {29'h0, status_q};
                `ATC_OFF_MASK:     rdata_d = {29'h0, mask_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `ATC_RESP_SLVERR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control, buffers and counter
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d       = ctrl_q;
        reload_wr_d  = reload_wr_q;
        reload_act_d = reload_act_q;
        psc_wr_d     = psc_wr_q;
        psc_act_d    = psc_act_q;
        cmp_wr_d     = cmp_wr_q;
        cmp_act_d    = cmp_act_q;
        mask_d       = mask_q;
        status_d     = status_q;
        if (wr_go) begin
            case (awaddr_q)
                `ATC_OFF_CTRL: begin
                    ctrl_d = ctrl_w[15:0] & `ATC_CTRL_MASK;
                    // Alignment is only taken while stopped
                    if (ctrl_q[`ATC_B_RUN])
                        ctrl_d[`ATC_F_ALIGN_HI:`ATC_F_ALIGN_LO] = align;
                    if (centre || encoder_mode)
                        ctrl_d[`ATC_B_DIR] = ctrl_q[`ATC_B_DIR];
                end
                `ATC_OFF_RELOAD: begin
                    reload_wr_d = CNT_W'(wmerge(widen(reload_wr_q), wv,
                                                wstrb_q));
                    if (!ctrl_q[`ATC_B_RBUF])
                        reload_act_d = reload_wr_d;
                end
                `ATC_OFF_PRESCALE:
                    psc_wr_d = CNT_W'(wmerge(widen(psc_wr_q), wv, wstrb_q));
                `ATC_OFF_COMPARE:
                    cmp_wr_d = CNT_W'(wmerge(widen(cmp_wr_q), wv, wstrb_q));
                `ATC_OFF_MASK:
                    mask_d = wstrb_q[0] ? wv[2:0] : mask_q;
                default: ;
            endcase
        end
        if (trig_mode && trig_rise) begin
            ctrl_d[`ATC_B_RUN] = 1'b1;
        end
        if (upd_ev) begin
            reload_act_d = reload_wr_q;
            psc_act_d    = psc_wr_q;
            cmp_act_d    = cmp_wr_q;
            if (ctrl_q[`ATC_B_OSHOT]) ctrl_d[`ATC_B_RUN] = 1'b0;
        end
        if (centre || encoder_mode) ctrl_d[`ATC_B_DIR] = down_d;
        // Read clears, but a new event in the same cycle survives
        if (rd_go && s_axi_araddr == `ATC_OFF_STATUS) status_d = 3'h0;
        if (upd_irq)                    status_d[`ATC_ST_UPD] = 1'b1;
        if (cmp_hit)                    status_d[`ATC_ST_CMP] = 1'b1;
        if (trig_mode && trig_rise)     status_d[`ATC_ST_TRG] = 1'b1;
    end

    always_comb begin
        cnt_d  = cnt_q;
        pcnt_d = pcnt_q;
        down_d = down_q;
        if (!centre) down_d = ctrl_q[`ATC_B_DIR];
        if (encoder_mode) down_d = encoder_dir;
        if (ctrl_q[`ATC_B_RUN]) begin
            pcnt_d = psc_q_tick() ? '0 : pcnt_q + 1'b1;
            if (psc_q_tick()) begin
                if (centre && !encoder_mode) begin
                    if (!down_q && cnt_q == reload_act_q) begin
                        down_d = 1'b1;
                        cnt_d  = cnt_q - 1'b1;
                    end else if (down_q && cnt_q == '0) begin
                        down_d = 1'b0;
                        cnt_d  = cnt_q + 1'b1;
                    end else begin
                        cnt_d = down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                    end
                end else if (ovf) begin
                    cnt_d = down_q ? reload_act_q : '0;
                end else begin
                    cnt_d = down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                end
            end
        end
        if (sw_upd && !ctrl_q[`ATC_B_UINH]) begin
            pcnt_d = '0;
            cnt_d  = (down_q && !centre) ? reload_act_q : '0;
        end
    end

    // Sampling tick; reserved code 11 behaves as undivided
    always_comb begin
        div_d = div_q + 2'h1;
        case (ctrl_q[`ATC_F_DIV_HI:`ATC_F_DIV_LO])
            `ATC_DIV_2: sample_tick = div_q[0];
            `ATC_DIV_4: sample_tick = (div_q == 2'h3);
            default:    sample_tick = 1'b1;
        endcase
        upd_d = upd_ev;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wst_q <= atc_pkg::ATC_WR_IDLE;
            awaddr_q <= 12'h000;
            awhave_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            whave_q <= 1'b0;
            bresp_q <= `ATC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `ATC_RESP_OKAY;
            ctrl_q <= `ATC_CTRL_RESET;
            reload_wr_q <= '0;
            reload_act_q <= '0;
            psc_wr_q <= '0;
            psc_act_q <= '0;
            cmp_wr_q <= '0;
            cmp_act_q <= '0;
            status_q <= 3'h0;
            mask_q <= 3'h0;
            cnt_q <= '0;
            pcnt_q <= '0;
            down_q <= 1'b0;
            div_q <= 2'h0;
            upd_q <= 1'b0;
        end else begin
            wst_q <= wst_d;
            awaddr_q <= awaddr_d;
            awhave_q <= awhave_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            whave_q <= whave_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
            reload_wr_q <= reload_wr_d;
            reload_act_q <= reload_act_d;
            psc_wr_q <= psc_wr_d;
            psc_act_q <= psc_act_d;
            cmp_wr_q <= cmp_wr_d;
            cmp_act_q <= cmp_act_d;
            status_q <= status_d;
            mask_q <= mask_d;
            cnt_q <= cnt_d;
            pcnt_q <= pcnt_d;
            down_q <= down_d;
            div_q <= div_d;
            upd_q <= upd_d;
        end
    end

    assign count_value   = cnt_q;
    assign counting_down = down_q;
    assign update_event  = upd_q;
    assign irq           = |(status_q & mask_q);

endmodule : atc_timer_ctrl
`default_nettype wire

// >>> verilog/atc_defs.svh
// Constants of the advanced timer control block: offsets, fields, resets.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

`define ATC_OFF_CTRL      12'h000
`define ATC_OFF_RELOAD    12'h004
`define ATC_OFF_PRESCALE  12'h008
`define ATC_OFF_COMPARE   12'h00c
`define ATC_OFF_COUNT     12'h010
`define ATC_OFF_CMD       12'h014
`define ATC_OFF_STATUS    12'h018
`define ATC_OFF_MASK      12'h01c

`define ATC_B_RUN         0
`define ATC_B_UINH        1
`define ATC_B_URS         2
`define ATC_B_OSHOT       3
`define ATC_B_DIR         4
`define ATC_F_ALIGN_LO    5
`define ATC_F_ALIGN_HI    6
`define ATC_B_RBUF        7
`define ATC_F_DIV_LO      8
`define ATC_F_DIV_HI      9
`define ATC_CTRL_MASK     16'h03ff
`define ATC_CTRL_RESET    16'h0000

`define ATC_B_CMD_UPD     0
`define ATC_ST_UPD        0
`define ATC_ST_CMP        1
`define ATC_ST_TRG        2

`define ATC_ALIGN_EDGE    2'h0
`define ATC_ALIGN_DOWN    2'h1
`define ATC_ALIGN_UP      2'h2
`define ATC_DIV_1         2'h0
`define ATC_DIV_2         2'h1
`define ATC_DIV_4         2'h2

`define ATC_RESP_OKAY     2'h0
`define ATC_RESP_SLVERR   2'h2

`endif

// >>> verilog/atc_pkg.sv
// Types shared by the advanced timer control block.
// Assumes atc_defs.svh holds all numeric constants except the write state codes.
package atc_pkg;
    typedef enum logic [2:0] {
        ATC_WR_IDLE = 3'h1,
        ATC_WR_RESP = 3'h2,
        ATC_WR_HOLD = 3'h4
    } atc_wr_state_t;
endpackage : atc_pkg

// >>> verification/atc_timer_ctrl_props.sv
// Concurrent checks on the ports of the advanced timer control block.
// Assumes a bind from the testbench top file; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none

module atc_timer_ctrl_props (
    input wire logic        core_clk,       // Timer clock
    input wire logic        rst,            // Sync reset, active high
    input wire logic        s_axi_awvalid,  // Write address valid
    input wire logic        s_axi_awready,  // Write address ready
    input wire logic        s_axi_wvalid,   // Write data valid
    input wire logic        s_axi_wready,   // Write data ready
    input wire logic [1:0]  s_axi_bresp,    // Write response
    input wire logic        s_axi_bvalid,   // Write response valid
    input wire logic        s_axi_bready,   // Write response ready
    input wire logic        s_axi_arvalid,  // Read address valid
    input wire logic        s_axi_arready,  // Read address ready
    input wire logic [31:0] s_axi_rdata,    // Read data
    input wire logic        s_axi_rvalid,   // Read data valid
    input wire logic        s_axi_rready,   // Read data ready
    input wire logic        update_event,   // Update pulse
    input wire logic        sample_tick,    // Sampling tick
    input wire logic        irq             // Level interrupt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Bus handshakes
    // ----------------------------------------
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while rvalid");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    aw_block_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("new write accepted");

    // ----------------------------------------
    // Timer outputs
    // ----------------------------------------
    upd_pulse_a: assert property (update_event |=> !update_event)
        else $error("update pulse too long");
    tick_gap_a: assert property (!sample_tick ##1 !sample_tick ##1
        !sample_tick |=> sample_tick) else $error("tick gap over four");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=>
        !irq && !update_event) else $error("output active in reset");
endmodule : atc_timer_ctrl_props

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the advanced timer control block.
// Assumes atc_defs.svh on the include path; checker bound at the foot.
`include "atc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [11:0] CTRL = `ATC_OFF_CTRL;
    localparam logic [11:0] CMD  = `ATC_OFF_CMD;
    localparam logic [11:0] STAT = `ATC_OFF_STATUS;
    logic        core_clk, rst, trig_mode, trig_in, slave_update;
    logic        encoder_mode, encoder_dir, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        counting_down, update_event, sample_tick, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, x;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] count_value;
    int          n_fail, n_checks, n_upd, u, s, cyc_n;

    atc_timer_ctrl #(.CNT_W(16)) u_atc_timer_ctrl (.core_clk, .rst,
        .trig_mode, .encoder_mode, .encoder_dir, .trig_in, .slave_update,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .count_value, .counting_down, .update_event,
        .sample_tick, .irq);

    // ----------------------------------------
    // Clock, monitors and shared tasks
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc_n++;
        if (update_event === 1'b1) n_upd++;
        if (cyc_n == 20000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Both channels offered at once; each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] rs);
        int t;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 50) n_fail++;
        @(posedge core_clk);
    endtask : wr

    task automatic w(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chk(32'(rs), 32'(`ATC_RESP_OKAY));
    endtask : w

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (t >= 50) n_fail++;
        @(posedge core_clk);
    endtask : rd

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(CTRL, x);
        chk(x, 32'h0);
        w(CTRL, 32'hfc8e);
        rd(CTRL, x);
        chk(x, 32'h008e);
        wr(12'h040, 32'h1, r);
        chk(32'(r), 32'(`ATC_RESP_SLVERR));
        w(CTRL, 32'h0);
    endtask : t_reset

    task automatic t_run;
        w(`ATC_OFF_PRESCALE, 32'h0);
        w(`ATC_OFF_RELOAD, 32'h00ff);
        w(CMD, 32'h1);
        w(CTRL, 32'h1);
        x = 32'(count_value);
        cyc(5);
        chk(32'(count_value), x + 5);
        w(CTRL, 32'h0);
        x = 32'(count_value);
        cyc(8);
        chk(32'(count_value), x);
        w(CTRL, 32'h10);
        w(CTRL, 32'h11);
        x = 32'(count_value);
        cyc(5);
        chk(32'(count_value), x - 5);
        w(CTRL, 32'h0);
    endtask : t_run

    task automatic t_update;
        rd(STAT, x);
        u = n_upd;
        w(CTRL, 32'h2);
        w(CMD, 32'h1);
        slave_update <= 1'b1;
        cyc(6);
        slave_update <= 1'b0;
        cyc(6);
        chk(32'(n_upd - u), 32'h0);
        w(`ATC_OFF_MASK, 32'h1);
        w(CTRL, 32'h0);
        u = n_upd;
        w(CMD, 32'h1);
        cyc(4);
        chk(32'(n_upd - u), 32'h1);
        chk(32'(irq), 32'h1);
        rd(STAT, x);
        chk(32'(x[0]), 32'h1);
        cyc(2);
        chk(32'(irq), 32'h0);
        slave_update <= 1'b1;
        cyc(6);
        chk(32'(n_upd - u), 32'h2);
        slave_update <= 1'b0;
        rd(STAT, x);
        w(CTRL, 32'h4);
        w(CMD, 32'h1);
        cyc(4);
        chk(32'(n_upd - u), 32'h3);
        rd(STAT, x);
        chk(32'(x[0]), 32'h0);
    endtask : t_update

    task automatic t_modes;
        w(`ATC_OFF_RELOAD, 32'h4);
        w(CMD, 32'h1);
        w(CTRL, 32'h9);
        cyc(14);
        rd(CTRL, x);
        chk(x, 32'h8);
        w(CTRL, 32'h0);
        w(`ATC_OFF_COMPARE, 32'h2);
        w(CMD, 32'h1);
        w(CTRL, 32'h20);
        rd(STAT, x);
        w(CTRL, 32'h21);
        w(CTRL, 32'h20);
        rd(STAT, x);
        chk(32'(x[1]), 32'h0);
        w(CTRL, 32'h21);
        w(CTRL, 32'h20);
        rd(STAT, x);
        chk(32'(x[1]), 32'h1);
        w(CTRL, 32'h0);
        trig_mode <= 1'b1;
        cyc(2);
        trig_in <= 1'b1;
        cyc(8);
        rd(CTRL, x);
        chk(32'(x[0]), 32'h1);
        trig_in <= 1'b0;
        trig_mode <= 1'b0;
        w(CTRL, 32'h60);
        w(CTRL, 32'h71);
        s = 0;
        repeat (16) begin
            @(posedge core_clk);
            s = s | (counting_down === 1'b1 ? 2 : 1);
        end
        chk(32'(s), 32'h3);
        rd(CTRL, x);
        chk(x & 32'h6f, 32'h61);
        w(CTRL, 32'h60);
        w(CTRL, 32'h0);
        encoder_mode <= 1'b1;
        encoder_dir <= 1'b1;
        w(CTRL, 32'h1);
        cyc(2);
        rd(CTRL, x);
        chk(32'(x[4]), 32'h1);
        chk(32'(counting_down), 32'h1);
        w(CTRL, 32'h0);
        encoder_mode <= 1'b0;
        w(CTRL, 32'h0);
        cyc(2);
        chk(32'(counting_down), 32'h0);
    endtask : t_modes

    task automatic t_div;
        for (int d = 0; d < 4; d++) begin
            w(CTRL, 32'(d) << 8);
            s = 0;
            repeat (8) begin
                @(posedge core_clk);
                s = s + (sample_tick === 1'b1 ? 1 : 0);
            end
            chk(32'(s), (d == 1) ? 32'h4 : (d == 2) ? 32'h2 : 32'h8);
        end
        w(CTRL, 32'h0);
    endtask : t_div

    initial begin
        rst = 1'b1;
        {trig_mode, trig_in, slave_update, encoder_mode, encoder_dir} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_run();
        t_update();
        t_modes();
        t_div();
        summarize();
    end
endmodule : testbench

bind atc_timer_ctrl atc_timer_ctrl_props u_atc_timer_ctrl_props (.core_clk,
    .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .update_event, .sample_tick, .irq);

`default_nettype wire
